/* File: tgc_clk_predivider.sv */
// Synchroniser and predivider for the fast reference clock pin.
`timescale 1ns/1ps
module tgc_clk_predivider (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset_n,
   // Fast clock pin and control.
   input wire logic fastRefClk,
   input wire logic runEnable,
   input wire logic [1:0] predivider,
   // Divided tick.
   output logic fastTick
);

   logic sync1_reg, sync1_next;
   logic sync2_reg, sync2_next;
   logic last_reg, last_next;
   logic [1:0] cnt_reg, cnt_next;
   logic tick_reg, tick_next;

   // Last count value of one divided period; code 3 is unused and passes undivided.
   function automatic logic [1:0] divLimit(input logic [1:0] sel);
      case (sel)
         2'h1: divLimit = 2'h1;
         2'h2: divLimit = 2'h3;
         default: divLimit = 2'h0;
      endcase
   endfunction : divLimit

   always_comb begin
      sync1_next = fastRefClk;
      sync2_next = sync1_reg;
      last_next = sync2_reg;
      cnt_next = cnt_reg;
      tick_next = 1'b0;
      if (!runEnable) begin
         cnt_next = 2'h0;
      end else if (sync2_reg && !last_reg) begin
         if (cnt_reg >= divLimit(predivider)) begin
            cnt_next = 2'h0;
            tick_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         last_reg <= 1'b0;
         cnt_reg <= 2'h0;
         tick_reg <= 1'b0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         last_reg <= last_next;
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign fastTick = tick_reg;

endmodule : tgc_clk_predivider

/* File: tgc_fast_osc_model.sv */
// Fast reference oscillator model that runs only while the device enables it.
`timescale 1ns/1ps
module tgc_fast_osc_model #(
   parameter real HALF_NS = 125.0
) (
   // Enable from the device.
   input wire logic oscEnable,
   // Oscillator pin.
   output logic oscOut
);
   // A stopped oscillator rests low; the odd start offset keeps it unrelated to the system clock.
   initial begin
      oscOut = 1'b0;
      #1.3;
      forever begin
         #(HALF_NS);
         oscOut = oscEnable ? ~oscOut : 1'b0;
      end
   end
endmodule : tgc_fast_osc_model

/* File: tgc_general_config.sv */
// General configuration, oscillator control, interrupt sources and identifier store.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "tgc_general_map.svh"

module tgc_general_config #(
   parameter int SETTLE0_CYC = (`TGC_SETTLE0_NS * `TGC_CLK_MHZ + 999) / 1000,
   parameter int SETTLE1_CYC = (`TGC_SETTLE1_NS * `TGC_CLK_MHZ + 999) / 1000,
   parameter int SETTLE2_CYC = (`TGC_SETTLE2_NS * `TGC_CLK_MHZ + 999) / 1000,
   parameter int SETTLE3_CYC = (`TGC_SETTLE3_NS * `TGC_CLK_MHZ + 999) / 1000,
   parameter int CNT_W = 21
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset_n,
   // Register port.
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   // Fast reference clock pin.
   input wire logic fastRefClk,
   // Measurement core events.
   input wire logic measRequest,
   input wire logic tduOverflow,
   input wire logic hitsDone,
   input wire logic aluDone,
   input wire logic [31:0] aluResult,
   // Controls toward the core and oscillators.
   output logic fastOscEnable,
   output logic fastClockReady,
   output logic fastClockTick,
   output logic lowCurrent32k,
   output logic startNoiseEnable,
   output logic phaseNoiseEnable,
   output logic [1:0] resolutionMode,
   output logic measInit,
   output logic irqRequest
);

   logic [`TGC_CFG_W-1:0] cfg_reg, cfg_next;
   logic [3:0] irqEn_reg, irqEn_next;
   logic [31:0] result_reg, result_next;
   logic [7:0] idStage_reg [`TGC_NVM_WORDS], idStage_next [`TGC_NVM_WORDS];
   logic [31:0] nvm_reg [`TGC_NVM_WORDS], nvm_next [`TGC_NVM_WORDS];
   logic nvmDone_reg, nvmDone_next;
   logic [3:0] pend_reg, pend_next;
   logic irq_reg, irq_next;
   logic reinit_reg, reinit_next;
   logic init_reg, init_next;
   tgc_general_pkg::tgc_osc_state_t osc_reg, osc_next;
   logic [CNT_W-1:0] settle_reg, settle_next;
   logic oscEn_reg, oscEn_next;
   logic ready_reg, ready_next;
   logic lowCur_reg, noise_reg, phase_reg;
   logic [1:0] res_reg, res_next;
   logic [31:0] rd_reg, rd_next;

   logic cmdWr, porCmd, initCmd, storeCmd, recallCmd, initNow;
   logic [3:0] events;
   logic [2:0] oscCode;
   logic [2:0] idIdx;

   function automatic logic [CNT_W-1:0] settleCycles(input logic [2:0] code);
      case (code)
         3'h2: settleCycles = CNT_W'(SETTLE0_CYC - 1);
         3'h3: settleCycles = CNT_W'(SETTLE1_CYC - 1);
         3'h4: settleCycles = CNT_W'(SETTLE2_CYC - 1);
         default: settleCycles = CNT_W'(SETTLE3_CYC - 1);
      endcase
   endfunction : settleCycles

   assign cmdWr = regWrite && (regAddr == `TGC_OFS_CMD);
   assign porCmd = cmdWr && (regWrData[7:0] == `TGC_CMD_POR);
   assign initCmd = cmdWr && (regWrData[7:0] == `TGC_CMD_INIT);
   assign storeCmd = cmdWr && (regWrData[7:0] == `TGC_CMD_NVM_STORE);
   assign recallCmd = cmdWr && (regWrData[7:0] == `TGC_CMD_NVM_RECALL);
   assign initNow = initCmd || porCmd || reinit_reg;
   assign oscCode = cfg_reg[`TGC_CFG_OSC_LSB +: 3];
   assign idIdx = regAddr[4:2];
   assign events[`TGC_EV_TIMEOUT] = tduOverflow;
   assign events[`TGC_EV_HITS] = hitsDone;
   assign events[`TGC_EV_ALU] = aluDone;
   assign events[`TGC_EV_NVM] = nvmDone_reg;

   // Configuration, identifier staging and nonvolatile words.
   always_comb begin
      cfg_next = cfg_reg;
      irqEn_next = irqEn_reg;
      idStage_next = idStage_reg;
      nvm_next = nvm_reg;
      nvmDone_next = storeCmd || recallCmd;
      if (regWrite && regAddr == `TGC_OFS_CONFIG) begin
         cfg_next = regWrData[`TGC_CFG_W-1:0];
      end
      if (regWrite && regAddr == `TGC_OFS_IRQ_EN) begin
         irqEn_next = regWrData[3:0];
      end
      if (regWrite && regAddr == `TGC_OFS_ID_STAGE && regWrData[2:0] < 3'h7) begin
         idStage_next[regWrData[2:0]] = regWrData[15:8];
      end
      if (storeCmd) begin
         for (int i = 0; i < `TGC_NVM_WORDS; i++) begin
            nvm_next[i] = {idStage_reg[i], 24'h000000};
         end
         nvm_next[0][`TGC_CFG_W-1:0] = cfg_reg;
      end
      if (recallCmd) begin
         cfg_next = nvm_reg[0][`TGC_CFG_W-1:0];
      end
      if (porCmd) begin
         cfg_next = `TGC_CFG_RESET;
         irqEn_next = `TGC_IRQ_EN_RESET;
      end
   end

   always_ff @(posedge clk_sys) begin
      nvm_reg <= nvm_next;
      if (!reset_n) begin
         cfg_reg <= `TGC_CFG_RESET;
         irqEn_reg <= `TGC_IRQ_EN_RESET;
         idStage_reg <= '{default: 8'h00};
         nvmDone_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         irqEn_reg <= irqEn_next;
         idStage_reg <= idStage_next;
         nvmDone_reg <= nvmDone_next;
      end
   end

   // Events, interrupt request, re-init and result.
   always_comb begin
      pend_next = (pend_reg & {4{~initNow}}) | events;
      irq_next = (irq_reg && !initNow) || ((events & irqEn_reg) != 4'h0);
      reinit_next = cfg_reg[`TGC_CFG_REINIT_BIT] && irq_next && !irq_reg;
      init_next = initNow;
      result_next = result_reg;
      if (aluDone) begin
         result_next = aluResult;
      end
      if (tduOverflow && cfg_reg[`TGC_CFG_ERRVAL_BIT]) begin
         result_next = `TGC_ERROR_VALUE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pend_reg <= 4'h0;
         irq_reg <= 1'b0;
         reinit_reg <= 1'b0;
         init_reg <= 1'b0;
         result_reg <= 32'h00000000;
      end else begin
         pend_reg <= pend_next;
         irq_reg <= irq_next;
         reinit_reg <= reinit_next;
         init_reg <= init_next;
         result_reg <= result_next;
      end
   end

   // Fast oscillator start and settling.
   always_comb begin
      osc_next = osc_reg;
      settle_next = settle_reg;
      case (osc_reg)
         tgc_general_pkg::OSC_IDLE: begin
            if (oscCode == `TGC_OSC_CONT) begin
               osc_next = tgc_general_pkg::OSC_RUN;
            end else if (measRequest && oscCode >= `TGC_OSC_SETTLE_MIN &&
                         oscCode <= `TGC_OSC_SETTLE_MAX) begin
               osc_next = tgc_general_pkg::OSC_SETTLE;
               settle_next = settleCycles(oscCode);
            end
         end
         tgc_general_pkg::OSC_SETTLE: begin
            if (oscCode < `TGC_OSC_SETTLE_MIN || oscCode > `TGC_OSC_SETTLE_MAX) begin
               osc_next = tgc_general_pkg::OSC_IDLE;
            end else if (settle_reg == '0) begin
               osc_next = tgc_general_pkg::OSC_RUN;
            end else begin
               settle_next = settle_reg - CNT_W'(1);
            end
         end
         tgc_general_pkg::OSC_RUN: begin
            if (oscCode == `TGC_OSC_OFF || oscCode > `TGC_OSC_SETTLE_MAX) begin
               osc_next = tgc_general_pkg::OSC_IDLE;
            end else if (oscCode != `TGC_OSC_CONT && irq_next && !irq_reg) begin
               osc_next = tgc_general_pkg::OSC_IDLE;
            end
         end
         default: begin
            osc_next = tgc_general_pkg::OSC_IDLE;
         end
      endcase
      oscEn_next = osc_next != tgc_general_pkg::OSC_IDLE;
      ready_next = osc_next == tgc_general_pkg::OSC_RUN;
      if (cfg_reg[`TGC_CFG_QUAD_BIT] && cfg_reg[`TGC_CFG_MODE2_BIT]) begin
         res_next = tgc_general_pkg::RES_QUAD;
      end else if (cfg_reg[`TGC_CFG_DOUBLE_BIT]) begin
         res_next = tgc_general_pkg::RES_DOUBLE;
      end else begin
         res_next = tgc_general_pkg::RES_SINGLE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         osc_reg <= tgc_general_pkg::OSC_IDLE;
         settle_reg <= '0;
         oscEn_reg <= 1'b0;
         ready_reg <= 1'b0;
         res_reg <= 2'h0;
         lowCur_reg <= 1'b0;
         noise_reg <= 1'b0;
         phase_reg <= 1'b0;
      end else begin
         osc_reg <= osc_next;
         settle_reg <= settle_next;
         oscEn_reg <= oscEn_next;
         ready_reg <= ready_next;
         res_reg <= res_next;
         lowCur_reg <= cfg_reg[`TGC_CFG_LOWCUR_BIT];
         noise_reg <= cfg_reg[`TGC_CFG_NOISE_BIT];
         phase_reg <= !cfg_reg[`TGC_CFG_PHASEDIS_BIT];
      end
   end

   tgc_clk_predivider u_prediv (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .fastRefClk(fastRefClk),
      .runEnable(ready_reg),
      .predivider(cfg_reg[`TGC_CFG_PREDIV_LSB +: 2]),
      .fastTick(fastClockTick)
   );

   // Read data, valid in the cycle after the strobe only.
   always_comb begin
      rd_next = 32'h00000000;
      if (regRead) begin
         if (regAddr == `TGC_OFS_CONFIG) begin
            rd_next[`TGC_CFG_W-1:0] = cfg_reg;
         end else if (regAddr == `TGC_OFS_IRQ_EN) begin
            rd_next[3:0] = irqEn_reg;
         end else if (regAddr == `TGC_OFS_STATUS) begin
            rd_next[9:0] = {res_reg, 1'b0, ready_reg, oscEn_reg, irq_reg, pend_reg};
         end else if (regAddr == `TGC_OFS_RESULT) begin
            rd_next = result_reg;
         end else if (regAddr[7:5] == 3'h2 && regAddr[1:0] == 2'h0 && idIdx < 3'h7) begin
            rd_next[7:0] = nvm_reg[idIdx][31:24];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rd_reg <= 32'h00000000;
      end else begin
         rd_reg <= rd_next;
      end
   end

   assign regRdData = rd_reg;
   assign fastOscEnable = oscEn_reg;
   assign fastClockReady = ready_reg;
   assign lowCurrent32k = lowCur_reg;
   assign startNoiseEnable = noise_reg;
   assign phaseNoiseEnable = phase_reg;
   assign resolutionMode = res_reg;
   assign measInit = init_reg;
   assign irqRequest = irq_reg;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   sequence storeSeq;
      regWrite && regAddr == `TGC_OFS_CMD && regWrData[7:0] == `TGC_CMD_NVM_STORE;
   endsequence

   sequence armedSeq;
      irqEn_reg[`TGC_EV_NVM] && !initNow;
   endsequence

   irq_hold_a: assert property (irqRequest && !initNow |=> irqRequest)
      else $error("interrupt request dropped without init");
   irq_masked_a: assert property (!irqRequest && (events & irqEn_reg) == 4'h0 |=> !irqRequest)
      else $error("interrupt raised by a disabled source");
   timeout_irq_a: assert property (tduOverflow && irqEn_reg[0] |=> irqRequest)
      else $error("overflow did not raise interrupt");
   hits_irq_a: assert property (hitsDone && irqEn_reg[1] |=> irqRequest)
      else $error("hit completion did not raise interrupt");
   alu_irq_a: assert property (aluDone && irqEn_reg[2] |=> irqRequest)
      else $error("result completion did not raise interrupt");
   nvm_irq_a: assert property (storeSeq ##1 armedSeq |=> irqRequest)
      else $error("store completion did not raise interrupt");
   error_value_a: assert property (tduOverflow && cfg_reg[`TGC_CFG_ERRVAL_BIT]
      |=> result_reg == `TGC_ERROR_VALUE)
      else $error("timeout did not load error value");
   auto_reinit_a: assert property ($rose(irqRequest) && cfg_reg[`TGC_CFG_REINIT_BIT]
      |=> measInit)
      else $error("no internal init after interrupt");
   por_config_a: assert property (porCmd |=> cfg_reg == `TGC_CFG_RESET)
      else $error("reset command left configuration");
   init_keep_a: assert property (initCmd |=> $stable(cfg_reg))
      else $error("init command changed configuration");
   quad_mode_a: assert property (resolutionMode == tgc_general_pkg::RES_QUAD
      |-> $past(cfg_reg[`TGC_CFG_MODE2_BIT]))
      else $error("fourfold resolution outside second mode");
   settle_done_a: assert property (osc_reg == tgc_general_pkg::OSC_SETTLE && settle_reg == '0
      && oscCode >= `TGC_OSC_SETTLE_MIN && oscCode <= `TGC_OSC_SETTLE_MAX
      |=> fastClockReady)
      else $error("clock not ready after settling");
   noise_ctrl_a: assert property (##1 startNoiseEnable == $past(cfg_reg[`TGC_CFG_NOISE_BIT]))
      else $error("start noise output mismatch");

endmodule : tgc_general_config

/* File: tgc_general_config_tb.sv */
// Self-checking testbench of the general config block.
`timescale 1ns/1ps
`include "tgc_general_map.svh"
module tgc_general_config_tb;
   localparam logic [7:0] CFG = `TGC_OFS_CONFIG;
   localparam logic [7:0] IEN = `TGC_OFS_IRQ_EN;
   localparam logic [7:0] CMD = `TGC_OFS_CMD;
   localparam logic [7:0] IDS = `TGC_OFS_ID_STAGE;
   logic clk_sys;
   logic reset_n;
   logic [7:0] regAddr;
   logic [31:0] regWrData;
   logic regWrite;
   logic regRead;
   logic [31:0] regRdData;
   logic fastRefClk;
   logic [3:0] ev;
   logic [31:0] aluResult;
   logic fastOscEnable;
   logic fastClockReady;
   logic fastClockTick;
   logic lowCurrent32k;
   logic startNoiseEnable;
   logic phaseNoiseEnable;
   logic [1:0] resolutionMode;
   logic measInit;
   logic irqRequest;
   int nErrors = 0;
   int checks = 0;
   int cycleCount = 0;

   tgc_general_config #(.SETTLE0_CYC(10), .SETTLE1_CYC(20), .SETTLE2_CYC(30),
      .SETTLE3_CYC(40)) dut (
      .clk_sys, .reset_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
      .fastRefClk, .measRequest(ev[3]), .tduOverflow(ev[0]), .hitsDone(ev[1]),
      .aluDone(ev[2]), .aluResult, .fastOscEnable, .fastClockReady, .fastClockTick,
      .lowCurrent32k, .startNoiseEnable, .phaseNoiseEnable, .resolutionMode,
      .measInit, .irqRequest);

   tgc_fast_osc_model osc (.oscEnable(fastOscEnable), .oscOut(fastRefClk));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycleCount <= cycleCount + 1;
      if (cycleCount == 30000) begin
         nErrors++;
         testDone();
      end
   end

   task automatic testDone;
      $display("errors %0d checks %0d", nErrors, checks);
      if (nErrors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : testDone

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         nErrors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic peek(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : peek

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1;
      chk(regRdData, e);
   endtask : rd

   task automatic pulse(input int i);
      @(posedge clk_sys);
      ev[i] <= 1'b1;
      @(posedge clk_sys);
      ev <= 4'h0;
   endtask : pulse

   task automatic initCount(input int n, output int c);
      c = 0;
      repeat (n) begin
         #1;
         c += measInit;
         @(posedge clk_sys);
      end
   endtask : initCount

   task automatic waitReady(output int n);
      n = 0;
      #1;
      while (fastClockReady !== 1'b1 && n < 100) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask : waitReady

   task automatic tReset;
      peek(2);
      rd(CFG, 32'h0110);
      rd(IEN, 32'h0);
      rd(8'h30, 32'h0);
      chk(lowCurrent32k, 1);
      chk(phaseNoiseEnable, 1);
   endtask : tReset

   task automatic tPor;
      int c;
      wr(CFG, 32'h4a21);
      wr(IEN, 32'hf);
      wr(CMD, 32'h70);
      initCount(4, c);
      chk(c, 1);
      rd(CFG, 32'h4a21);
      wr(CMD, 32'h50);
      rd(CFG, 32'h0110);
      rd(IEN, 32'h0);
   endtask : tPor

   task automatic tCfgOut;
      wr(CFG, 32'h0611);
      peek(2);
      chk({startNoiseEnable, phaseNoiseEnable, lowCurrent32k}, 3'b100);
      wr(CFG, 32'h0110);
      peek(2);
      chk({startNoiseEnable, phaseNoiseEnable, lowCurrent32k}, 3'b011);
   endtask : tCfgOut

   task automatic tRes;
      logic [15:0] cfg[4] = '{16'h4110, 16'ha110, 16'h2110, 16'hc110};
      logic [1:0] exp[4] = '{2'h1, 2'h2, 2'h0, 2'h1};
      for (int i = 0; i < 4; i++) begin
         wr(CFG, {16'h0, cfg[i]});
         peek(2);
         chk(resolutionMode, exp[i]);
      end
      wr(CFG, 32'h0110);
   endtask : tRes

   task automatic fire(input int i);
      if (i == 3) wr(CMD, 32'hc0);
      else pulse(i);
      peek(3);
   endtask : fire

   task automatic tIrq;
      for (int i = 0; i < 4; i++) begin
         wr(IEN, 32'hf ^ (32'h1 << i));
         fire(i);
         chk(irqRequest, 0);
         wr(CMD, 32'h70);
         wr(IEN, 32'h1 << i);
         fire(i);
         chk(irqRequest, 1);
         rd(`TGC_OFS_STATUS, 32'h70 | (32'h1 << i));
         wr(CMD, 32'h70);
         peek(2);
         chk(irqRequest, 0);
      end
   endtask : tIrq

   task automatic tErrVal;
      @(posedge clk_sys);
      aluResult <= 32'h1234abcd;
      pulse(2);
      rd(`TGC_OFS_RESULT, 32'h1234abcd);
      pulse(0);
      rd(`TGC_OFS_RESULT, 32'h1234abcd);
      wr(CFG, 32'h1110);
      pulse(0);
      rd(`TGC_OFS_RESULT, `TGC_ERROR_VALUE);
      wr(CFG, 32'h0110);
      wr(CMD, 32'h70);
   endtask : tErrVal

   task automatic tReinit;
      int c;
      wr(CFG, 32'h0910);
      wr(IEN, 32'h2);
      pulse(1);
      initCount(6, c);
      chk(c, 1);
      chk(irqRequest, 0);
      wr(CFG, 32'h0110);
   endtask : tReinit

   task automatic tOsc;
      int n;
      int t;
      for (int k = 0; k < 4; k++) begin
         t = 10 * (k + 1);
         wr(CFG, 32'h0100);
         peek(3);
         chk(fastOscEnable, 0);
         wr(IEN, 32'h1);
         wr(CFG, 32'h0100 | ((k + 2) << 4));
         pulse(3);
         waitReady(n);
         chk({31'h0, n >= t && n <= t + 3}, 1);
         chk(fastOscEnable, 1);
         pulse(0);
         peek(3);
         chk(fastOscEnable, 0);
         wr(CMD, 32'h70);
      end
   endtask : tOsc

   task automatic tDiv;
      int n;
      int t;
      for (int p = 0; p < 4; p++) begin
         wr(CFG, 32'h0110 | p);
         waitReady(n);
         peek(8);
         n = 0;
         repeat (2000) begin
            @(posedge clk_sys);
            #1;
            n += fastClockTick;
         end
         t = (p == 3) ? 32 : 32 >> p;
         chk({31'h0, n >= t - 1 && n <= t + 1}, 1);
      end
   endtask : tDiv

   task automatic tId;
      for (int i = 0; i < 7; i++) wr(IDS, ((32'h30 + i) << 8) | i);
      wr(IDS, 32'hff07);
      wr(CFG, 32'h0312);
      wr(CMD, 32'hc0);
      wr(CMD, 32'h50);
      rd(CFG, 32'h0110);
      wr(CMD, 32'hf0);
      rd(CFG, 32'h0312);
      for (int i = 0; i < 7; i++) rd(`TGC_OFS_ID_BASE + 8'(4 * i), 32'h30 + i);
   endtask : tId

   initial begin
      reset_n = 1'b0;
      regAddr = 8'h00;
      regWrData = 32'h0;
      regWrite = 1'b0;
      regRead = 1'b0;
      ev = 4'h0;
      aluResult = 32'h0;
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      tReset();
      tPor();
      tCfgOut();
      tRes();
      tIrq();
      tErrVal();
      tReinit();
      tOsc();
      tDiv();
      tId();
      testDone();
   end
endmodule : tgc_general_config_tb

/* File: tgc_general_map.svh */
// Register map, field positions, reset values and timing constants of the general config block.
`ifndef TGC_GENERAL_MAP_SVH
`define TGC_GENERAL_MAP_SVH

`define TGC_CLK_MHZ 250
`define TGC_SETTLE0_NS 480000
`define TGC_SETTLE1_NS 1460000
`define TGC_SETTLE2_NS 2440000
`define TGC_SETTLE3_NS 5140000

`define TGC_OFS_CONFIG 8'h00
`define TGC_OFS_IRQ_EN 8'h04
`define TGC_OFS_STATUS 8'h08
`define TGC_OFS_CMD 8'h0c
`define TGC_OFS_RESULT 8'h10
`define TGC_OFS_ID_STAGE 8'h14
`define TGC_OFS_ID_BASE 8'h40

`define TGC_CFG_W 16
`define TGC_CFG_RESET 16'h0110
`define TGC_CFG_PREDIV_LSB 0
`define TGC_CFG_OSC_LSB 4
`define TGC_CFG_LOWCUR_BIT 8
`define TGC_CFG_NOISE_BIT 9
`define TGC_CFG_PHASEDIS_BIT 10
`define TGC_CFG_REINIT_BIT 11
`define TGC_CFG_ERRVAL_BIT 12
`define TGC_CFG_QUAD_BIT 13
`define TGC_CFG_DOUBLE_BIT 14
`define TGC_CFG_MODE2_BIT 15

`define TGC_OSC_OFF 3'h0
`define TGC_OSC_CONT 3'h1
`define TGC_OSC_SETTLE_MIN 3'h2
`define TGC_OSC_SETTLE_MAX 3'h5

`define TGC_EV_TIMEOUT 0
`define TGC_EV_HITS 1
`define TGC_EV_ALU 2
`define TGC_EV_NVM 3
`define TGC_IRQ_EN_RESET 4'h0

`define TGC_CMD_POR 8'h50
`define TGC_CMD_INIT 8'h70
`define TGC_CMD_NVM_STORE 8'hc0
`define TGC_CMD_NVM_RECALL 8'hf0

`define TGC_NVM_WORDS 7
`define TGC_ERROR_VALUE 32'hffffffff

`endif

/* File: tgc_general_pkg.sv */
// Types shared by the general config block.
package tgc_general_pkg;

   typedef enum logic [2:0] {
      OSC_IDLE = 3'b001,
      OSC_SETTLE = 3'b010,
      OSC_RUN = 3'b100
   } tgc_osc_state_t;

   typedef enum logic [1:0] {
      RES_SINGLE = 2'h0,
      RES_DOUBLE = 2'h1,
      RES_QUAD = 2'h2
   } tgc_res_t;

endpackage : tgc_general_pkg
